//--- hw/hrmc_pkg.sv
// Constants and carrier types of the hub register front end.
// How it works
// - Every register is reachable from the local target port and the link channel.
// - Transmit block 0x32-0x3A reads the port in 0x32[4], writes all enabled ports.
// - Receive block 0x4C-0x7F reads port 0x4C[5:4], writes every port enabled in 0x4C[3:0].
// - Each of four receive ports owns its own debug bytes at 0xD0-0xDF.
// - Address field bits 7:1 always read the address in use, strap when not overridden.
// - Override bit set makes the field writable and the device answers at it.
// - Reload bit restarts ROM load, clears itself, done flag reports completion.
// - Full reset bit resets all logic and registers, then clears itself.
// - Keep-registers reset bit resets logic only, registers stay, bit clears itself.
// - Mode bit 0 and no locked feeding port puts the transmit port in high impedance.
// - Mode bit 1, sleep select 1, output enable 1 and no locked feeding port keeps it running, parked in LP-11.
// - Sleep select 1 with output enable 0 forces transmit outputs to high impedance.
// - Lock low with sleep select 0 and mode bit 1 drives the transmit outputs to HS-0.
// - Parity checker enable bit turns link parity checking on or off.
// - Read-then-clear fields clear after a read; self-clearing bits return to zero.
// - Device state bit 6 reports that ROM initialisation has finished.
package hrmc_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_TARGET    = 8'h00;
  localparam logic [7:0] ADDR_RESET     = 8'h01;
  localparam logic [7:0] ADDR_GENCFG    = 8'h02;
  localparam logic [7:0] ADDR_DEVSTATE  = 8'h04;
  localparam logic [7:0] ADDR_TX_PAGE   = 8'h32;
  localparam logic [7:0] ADDR_TX_FIRST  = 8'h33;
  localparam logic [7:0] ADDR_TX_LAST   = 8'h3A;
  localparam logic [7:0] ADDR_RX_PAGE   = 8'h4C;
  localparam logic [7:0] ADDR_RX_EVENTS = 8'h4D;
  localparam logic [7:0] ADDR_RX_FIRST  = 8'h4E;
  localparam logic [7:0] ADDR_RX_LAST   = 8'h7F;
  localparam logic [7:0] ADDR_DBG_FIRST = 8'hD0;
  localparam logic [7:0] ADDR_DBG_LAST  = 8'hDF;

  // Field positions.
  localparam int TGT_OVERRIDE_BIT = 0;
  localparam int RST_KEEP_BIT     = 0;
  localparam int RST_FULL_BIT     = 1;
  localparam int RST_RELOAD_BIT   = 2;
  localparam int RST_SPARE_BIT    = 5;
  localparam int CFG_PARITY_BIT   = 1;
  localparam int CFG_SLEEP_BIT    = 2;
  localparam int CFG_OEN_BIT      = 3;
  localparam int CFG_OEMODE_BIT   = 4;
  localparam int DEV_DONE_BIT     = 6;
  localparam int DEV_CKSUM_BIT    = 7;
  localparam int TXP_RDSEL_BIT    = 4;
  localparam int RXP_RDSEL_LSB    = 4;

  // Reset values.
  localparam logic [4:0] GENCFG_RESET   = 5'h1E;
  localparam logic [5:0] DEV_RSVD_VALUE = 6'h02;
  localparam logic [1:0] TX_WEN_RESET   = 2'h0;
  localparam logic [3:0] RX_WEN_RESET   = 4'h0;

  // Block sizes.
  localparam int NUM_RX    = 4;
  localparam int NUM_TX    = 2;
  localparam int TX_BYTES  = 8;
  localparam int RX_BYTES  = 50;
  localparam int DBG_BYTES = 16;

  typedef enum logic [1:0] {
    HRMC_TX_NORMAL = 2'b00,
    HRMC_TX_HIZ    = 2'b01,
    HRMC_TX_LP11   = 2'b10,
    HRMC_TX_HS0    = 2'b11
  } hrmc_tx_mode_t;

  typedef enum logic [0:0] {
    HRMC_ROM_IDLE = 1'b0,
    HRMC_ROM_LOAD = 1'b1
  } hrmc_rom_t;

  // One register access from a decoded target or channel transaction.
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hrmc_req_t;

  typedef struct packed {
    logic [6:0]                             strap_addr;
    logic                                   strap_taken;
    logic [6:0]                             prog_addr;
    logic                                   override;
    logic                                   spare_rst;
    logic [4:0]                             gen_cfg;
    logic                                   tx_rdsel;
    logic [NUM_TX-1:0]                      tx_wen;
    logic [1:0]                             rx_rdsel;
    logic [NUM_RX-1:0]                      rx_wen;
    logic [NUM_RX-1:0][7:0]                 rx_events;
    logic [NUM_TX-1:0][TX_BYTES-1:0][7:0]   tx_regs;
    logic [NUM_RX-1:0][RX_BYTES-1:0][7:0]   rx_regs;
    logic [NUM_RX-1:0][DBG_BYTES-1:0][7:0]  dbg_regs;
    hrmc_rom_t                              rom_state;
    logic                                   init_done;
    logic                                   cksum_ok;
    logic                                   rom_load;
    logic                                   full_reset;
    logic                                   logic_reset;
    logic                                   local_ack;
    logic                                   link_ack;
    logic [7:0]                             local_rdata;
    logic [7:0]                             link_rdata;
    logic [6:0]                             target_addr;
    logic                                   parity_en;
    hrmc_tx_mode_t [NUM_TX-1:0]             tx_mode;
  } hrmc_state_t;

endpackage : hrmc_pkg

//--- hw/hrmc_top.sv
// Register front end of the quad link deserializer hub.
`timescale 1ns/10ps
module hrmc_top (
  // Clock, reset and enable.
  input  wire logic                                 i_clock,
  input  wire logic                                 i_rst_n,
  input  wire logic                                 i_clk_en,
  // Local target port request and answer.
  input  wire hrmc_pkg::hrmc_req_t                  i_local_req,
  output logic                                      o_local_ack,
  output logic [7:0]                                o_local_rdata,
  // Link control channel request and answer.
  input  wire hrmc_pkg::hrmc_req_t                  i_link_req,
  output logic                                      o_link_ack,
  output logic [7:0]                                o_link_rdata,
  // Strap, ROM loader and receiver status.
  input  wire logic [6:0]                           i_strap_addr,
  input  wire logic                                 i_rom_done,
  input  wire logic                                 i_rom_cksum_ok,
  input  wire logic [hrmc_pkg::NUM_RX-1:0]          i_rx_lock,
  input  wire logic [hrmc_pkg::NUM_RX-1:0]          i_rx_tx_map,
  input  wire logic [hrmc_pkg::NUM_RX-1:0][7:0]     i_rx_event,
  // Control outputs.
  output logic [6:0]                                o_target_addr,
  output logic                                      o_rom_load,
  output logic                                      o_full_reset,
  output logic                                      o_logic_reset,
  output logic                                      o_parity_check_en,
  output hrmc_pkg::hrmc_tx_mode_t [hrmc_pkg::NUM_TX-1:0] o_tx_mode
);

  hrmc_pkg::hrmc_state_t st_q;
  hrmc_pkg::hrmc_state_t st_d;
  hrmc_pkg::hrmc_req_t   req;
  logic                  take_local;
  logic                  take_link;
  logic                  take;
  logic                  cor_read;
  logic [7:0]            rd;
  logic                  wr_full;
  logic                  any_lock;
  logic [7:0]            cor_ev;
  logic [7:0]            tx_peek;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Power-up contents; the loader starts at once so the done flag begins low.
  function automatic hrmc_pkg::hrmc_state_t reset_state();
    hrmc_pkg::hrmc_state_t s;
    s           = '0;
    s.gen_cfg   = hrmc_pkg::GENCFG_RESET;
    s.tx_wen    = hrmc_pkg::TX_WEN_RESET;
    s.rx_wen    = hrmc_pkg::RX_WEN_RESET;
    s.rom_state = hrmc_pkg::HRMC_ROM_LOAD;
    s.rom_load  = 1'b1;
    s.parity_en = hrmc_pkg::GENCFG_RESET[hrmc_pkg::CFG_PARITY_BIT];
    return s;
  endfunction : reset_state

  // Output state of one transmit port; sleep-disable wins over lock handling.
  function automatic hrmc_pkg::hrmc_tx_mode_t tx_mode_of(logic [4:0] cfg, logic locked);
    hrmc_pkg::hrmc_tx_mode_t m;
    m = hrmc_pkg::HRMC_TX_NORMAL;
    if (cfg[hrmc_pkg::CFG_SLEEP_BIT] && !cfg[hrmc_pkg::CFG_OEN_BIT]) begin
      m = hrmc_pkg::HRMC_TX_HIZ;
    end else if (!locked && !cfg[hrmc_pkg::CFG_OEMODE_BIT]) begin
      m = hrmc_pkg::HRMC_TX_HIZ;
    end else if (!locked && !cfg[hrmc_pkg::CFG_SLEEP_BIT]) begin
      m = hrmc_pkg::HRMC_TX_HS0;
    end else if (!locked) begin
      m = hrmc_pkg::HRMC_TX_LP11;
    end
    return m;
  endfunction : tx_mode_of

  // Read decode shared by both access sources.
  function automatic logic [7:0] read_byte(hrmc_pkg::hrmc_state_t s, logic [7:0] a);
    logic [7:0] v;
    logic [7:0] off_tx;
    logic [7:0] off_rx;
    logic [7:0] off_dbg;
    v       = 8'h00;
    off_tx  = a - hrmc_pkg::ADDR_TX_FIRST;
    off_rx  = a - hrmc_pkg::ADDR_RX_FIRST;
    off_dbg = a - hrmc_pkg::ADDR_DBG_FIRST;
    if (a == hrmc_pkg::ADDR_TARGET) begin
      v = {(s.override ? s.prog_addr : s.strap_addr), s.override};
    end else if (a == hrmc_pkg::ADDR_RESET) begin
      v = 8'h00;
      v[hrmc_pkg::RST_SPARE_BIT] = s.spare_rst;
    end else if (a == hrmc_pkg::ADDR_GENCFG) begin
      v = {3'h0, s.gen_cfg};
    end else if (a == hrmc_pkg::ADDR_DEVSTATE) begin
      v = {s.cksum_ok, s.init_done, hrmc_pkg::DEV_RSVD_VALUE};
    end else if (a == hrmc_pkg::ADDR_TX_PAGE) begin
      v = {3'h0, s.tx_rdsel, 2'h0, s.tx_wen};
    end else if (a >= hrmc_pkg::ADDR_TX_FIRST && a <= hrmc_pkg::ADDR_TX_LAST) begin
      v = s.tx_regs[s.tx_rdsel][off_tx[2:0]];
    end else if (a == hrmc_pkg::ADDR_RX_PAGE) begin
      v = {2'h0, s.rx_rdsel, s.rx_wen};
    end else if (a == hrmc_pkg::ADDR_RX_EVENTS) begin
      v = s.rx_events[s.rx_rdsel];
    end else if (a >= hrmc_pkg::ADDR_RX_FIRST && a <= hrmc_pkg::ADDR_RX_LAST) begin
      v = s.rx_regs[s.rx_rdsel][off_rx[5:0]];
    end else if (a >= hrmc_pkg::ADDR_DBG_FIRST && a <= hrmc_pkg::ADDR_DBG_LAST) begin
      v = s.dbg_regs[s.rx_rdsel][off_dbg[3:0]];
    end
    return v;
  endfunction : read_byte

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration between the two access sources.

  // The local port wins a tie; a source is not retaken while its ack shows,
  // which lets a requester hold valid until it sees the ack.
  assign take_local = i_local_req.valid && !st_q.local_ack;
  assign take_link  = i_link_req.valid && !st_q.link_ack && !take_local;
  assign take       = take_local || take_link;
  assign req        = take_local ? i_local_req : i_link_req;
  assign cor_read   = take && !req.write && (req.addr == hrmc_pkg::ADDR_RX_EVENTS);
  assign cor_ev     = i_rx_event[st_q.rx_rdsel];
  assign tx_peek    = st_q.tx_regs[st_q.tx_rdsel][0];
  assign rd         = read_byte(st_q, req.addr);

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  // All writes, self-clearing actions, loader and output mirrors in one place.
  always_comb begin
    logic [7:0] off;
    off             = 8'h00;
    st_d            = st_q;
    wr_full         = 1'b0;
    any_lock        = 1'b0;
    st_d.full_reset = 1'b0;
    st_d.logic_reset = 1'b0;
    st_d.local_ack  = 1'b0;
    st_d.link_ack   = 1'b0;
    // Strap is caught after release, never under reset.
    if (!st_q.strap_taken) begin
      st_d.strap_addr  = i_strap_addr;
      st_d.strap_taken = 1'b1;
    end
    // ROM loader.
    unique case (st_q.rom_state)
      hrmc_pkg::HRMC_ROM_IDLE: begin
        st_d.rom_load = 1'b0;
      end
      hrmc_pkg::HRMC_ROM_LOAD: begin
        if (i_rom_done) begin
          st_d.rom_state = hrmc_pkg::HRMC_ROM_IDLE;
          st_d.rom_load  = 1'b0;
          st_d.init_done = 1'b1;
          st_d.cksum_ok  = i_rom_cksum_ok;
        end
      end
    endcase
    // Register access.
    if (take) begin
      if (take_local) begin
        st_d.local_ack   = 1'b1;
        st_d.local_rdata = rd;
      end else begin
        st_d.link_ack   = 1'b1;
        st_d.link_rdata = rd;
      end
      if (cor_read) begin
        st_d.rx_events[st_q.rx_rdsel] = 8'h00;
      end
      if (req.write) begin
        if (req.addr == hrmc_pkg::ADDR_TARGET) begin
          st_d.override = req.wdata[hrmc_pkg::TGT_OVERRIDE_BIT];
          if (req.wdata[hrmc_pkg::TGT_OVERRIDE_BIT]) begin
            st_d.prog_addr = req.wdata[7:1];
          end
        end else if (req.addr == hrmc_pkg::ADDR_RESET) begin
          st_d.spare_rst = req.wdata[hrmc_pkg::RST_SPARE_BIT];
          if (req.wdata[hrmc_pkg::RST_RELOAD_BIT]) begin
            st_d.rom_state = hrmc_pkg::HRMC_ROM_LOAD;
            st_d.rom_load  = 1'b1;
            st_d.init_done = 1'b0;
          end
          st_d.logic_reset = req.wdata[hrmc_pkg::RST_KEEP_BIT];
          wr_full = req.wdata[hrmc_pkg::RST_FULL_BIT];
        end else if (req.addr == hrmc_pkg::ADDR_GENCFG) begin
          st_d.gen_cfg = req.wdata[4:0];
        end else if (req.addr == hrmc_pkg::ADDR_TX_PAGE) begin
          st_d.tx_rdsel = req.wdata[hrmc_pkg::TXP_RDSEL_BIT];
          st_d.tx_wen   = req.wdata[1:0];
        end else if (req.addr >= hrmc_pkg::ADDR_TX_FIRST &&
                     req.addr <= hrmc_pkg::ADDR_TX_LAST) begin
          off = req.addr - hrmc_pkg::ADDR_TX_FIRST;
          for (int p = 0; p < hrmc_pkg::NUM_TX; p++) begin
            if (st_q.tx_wen[p]) begin
              st_d.tx_regs[p][off[2:0]] = req.wdata;
            end
          end
        end else if (req.addr == hrmc_pkg::ADDR_RX_PAGE) begin
          st_d.rx_rdsel = req.wdata[hrmc_pkg::RXP_RDSEL_LSB+:2];
          st_d.rx_wen   = req.wdata[3:0];
        end else if (req.addr >= hrmc_pkg::ADDR_RX_FIRST &&
                     req.addr <= hrmc_pkg::ADDR_RX_LAST) begin
          off = req.addr - hrmc_pkg::ADDR_RX_FIRST;
          for (int r = 0; r < hrmc_pkg::NUM_RX; r++) begin
            if (st_q.rx_wen[r]) begin
              st_d.rx_regs[r][off[5:0]] = req.wdata;
            end
          end
        end else if (req.addr >= hrmc_pkg::ADDR_DBG_FIRST &&
                     req.addr <= hrmc_pkg::ADDR_DBG_LAST) begin
          off = req.addr - hrmc_pkg::ADDR_DBG_FIRST;
          for (int r = 0; r < hrmc_pkg::NUM_RX; r++) begin
            if (st_q.rx_wen[r]) begin
              st_d.dbg_regs[r][off[3:0]] = req.wdata;
            end
          end
        end
      end
    end
    // Events set after the read clear, so an event arriving with the read is not lost.
    for (int r = 0; r < hrmc_pkg::NUM_RX; r++) begin
      st_d.rx_events[r] = st_d.rx_events[r] | i_rx_event[r];
    end
    // Full reset reloads everything but the strap and the answer in flight.
    if (wr_full) begin
      st_d             = reset_state();
      st_d.strap_addr  = st_q.strap_addr;
      st_d.strap_taken = st_q.strap_taken;
      st_d.local_ack   = take_local;
      st_d.link_ack    = take_link;
      st_d.local_rdata = take_local ? rd : st_q.local_rdata;
      st_d.link_rdata  = take_link ? rd : st_q.link_rdata;
      st_d.full_reset  = 1'b1;
    end
    // Registered mirrors feeding the outputs.
    st_d.target_addr = st_d.override ? st_d.prog_addr : st_d.strap_addr;
    st_d.parity_en   = st_d.gen_cfg[hrmc_pkg::CFG_PARITY_BIT];
    for (int p = 0; p < hrmc_pkg::NUM_TX; p++) begin
      any_lock = 1'b0;
      for (int r = 0; r < hrmc_pkg::NUM_RX; r++) begin
        any_lock = any_lock | (i_rx_lock[r] && (i_rx_tx_map[r] == 1'(p)));
      end
      st_d.tx_mode[p] = tx_mode_of(st_q.gen_cfg, any_lock);
    end
  end

  // State register; the enable freezes every bit.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= reset_state();
    end else if (i_clk_en) begin
      st_q <= st_d;
    end
  end

  assign o_local_ack       = st_q.local_ack;
  assign o_local_rdata     = st_q.local_rdata;
  assign o_link_ack        = st_q.link_ack;
  assign o_link_rdata      = st_q.link_rdata;
  assign o_target_addr     = st_q.target_addr;
  assign o_rom_load        = st_q.rom_load;
  assign o_full_reset      = st_q.full_reset;
  assign o_logic_reset     = st_q.logic_reset;
  assign o_parity_check_en = st_q.parity_en;
  assign o_tx_mode         = st_q.tx_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_reload_write;
    i_clk_en && take && req.write && req.addr == hrmc_pkg::ADDR_RESET &&
      req.wdata[hrmc_pkg::RST_RELOAD_BIT] && !req.wdata[hrmc_pkg::RST_FULL_BIT];
  endsequence

  sequence s_loading;
    o_rom_load && !st_q.init_done;
  endsequence

  a_link_access_ack: assert property (i_clk_en && take_link |=> o_link_ack && !o_local_ack)
    else $error("link request not answered");
  a_tx_page_read: assert property (i_clk_en && take && !req.write &&
      req.addr == hrmc_pkg::ADDR_TX_FIRST |=>
      ($past(take_local) ? o_local_rdata : o_link_rdata) == $past(tx_peek))
    else $error("transmit page read wrong port");
  a_rx_broadcast: assert property (i_clk_en && take && req.write &&
      req.addr == hrmc_pkg::ADDR_RX_FIRST && st_q.rx_wen == 4'hF |=>
      st_q.rx_regs[0][0] == $past(req.wdata) && st_q.rx_regs[3][0] == $past(req.wdata))
    else $error("broadcast write missed a port");
  a_strap_address: assert property (!st_q.override && st_q.strap_taken |->
      o_target_addr == st_q.strap_addr)
    else $error("strapped address not in use");
  a_override_addr: assert property (st_q.override |-> o_target_addr == st_q.prog_addr)
    else $error("programmed address not in use");
  a_rom_reload: assert property (s_reload_write |=> s_loading)
    else $error("reload did not restart loader");
  a_full_reset: assert property (i_clk_en && wr_full |=>
      (o_full_reset && st_q.gen_cfg == hrmc_pkg::GENCFG_RESET) ##1
      (!o_full_reset || !$past(i_clk_en)))
    else $error("full reset wrong");
  a_keep_regs: assert property (i_clk_en && take && req.write &&
      req.addr == hrmc_pkg::ADDR_RESET && req.wdata == 8'h01 |=>
      o_logic_reset && $stable(st_q.gen_cfg))
    else $error("logic reset touched registers");
  a_tx_hiz_unlock: assert property (i_clk_en && !(|(i_rx_lock & ~i_rx_tx_map)) &&
      !st_q.gen_cfg[hrmc_pkg::CFG_OEMODE_BIT] |=> o_tx_mode[0] == hrmc_pkg::HRMC_TX_HIZ)
    else $error("unlocked port not high impedance");
  a_tx_lp11_park: assert property (i_clk_en && !(|(i_rx_lock & ~i_rx_tx_map)) &&
      st_q.gen_cfg[4:2] == 3'h7 |=> o_tx_mode[0] == hrmc_pkg::HRMC_TX_LP11)
    else $error("unlocked port not in LP-11");
  a_sleep_hiz: assert property (i_clk_en && st_q.gen_cfg[3:2] == 2'h1 |=>
      o_tx_mode[1] == hrmc_pkg::HRMC_TX_HIZ && o_tx_mode[0] == hrmc_pkg::HRMC_TX_HIZ)
    else $error("sleep disable not high impedance");
  a_hs0_drive: assert property (i_clk_en && !(|(i_rx_lock & ~i_rx_tx_map)) &&
      st_q.gen_cfg[4] && !st_q.gen_cfg[2] |=> o_tx_mode[0] == hrmc_pkg::HRMC_TX_HS0)
    else $error("lock low not HS-0");
  a_parity_enable: assert property (i_clk_en && take && req.write &&
      req.addr == hrmc_pkg::ADDR_GENCFG |=>
      o_parity_check_en == $past(req.wdata[hrmc_pkg::CFG_PARITY_BIT]))
    else $error("parity enable mismatch");
  a_cor_clear: assert property (i_clk_en && cor_read |=>
      st_q.rx_events[$past(st_q.rx_rdsel)] == $past(cor_ev))
    else $error("read-then-clear lost or kept flags");
  // A reset-control write in the same cycle can restart the loader, so it is left out.
  a_init_done: assert property (i_clk_en && i_rom_done &&
      st_q.rom_state == hrmc_pkg::HRMC_ROM_LOAD &&
      !(take && req.write && req.addr == hrmc_pkg::ADDR_RESET) |=>
      st_q.init_done && !o_rom_load)
    else $error("done flag not set");
  a_reserved_read: assert property (i_clk_en && take && !req.write &&
      req.addr inside {[8'h80:8'hAF]} |=>
      ($past(take_local) ? o_local_rdata : o_link_rdata) == 8'h00)
    else $error("reserved address not zero");

endmodule : hrmc_top

//--- tb/hrmc_req_model.sv
// Requester model standing in for a local target port or a link channel master.
`timescale 1ns/10ps
module hrmc_req_model (
  // Clock and answer.
  input  wire logic       i_clock,
  input  wire logic       i_ack,
  input  wire logic [7:0] i_rdata,
  // Request.
  output hrmc_pkg::hrmc_req_t o_req
);
  initial o_req = '0;
  // Holds the request until ack, then inverts the qualifiers so stale values never match.
  task automatic access(input logic w, input logic [7:0] a, d, input int gap,
                        output logic [7:0] rd, output logic ok);
    int n;
    repeat (gap + 1) @(posedge i_clock);
    #1 o_req = '{valid: 1'b1, write: w, addr: a, wdata: d};
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge i_clock);
      #1 ok = (i_ack === 1'b1);
    end
    rd = i_rdata;
    o_req = '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
  endtask : access
endmodule : hrmc_req_model

//--- tb/hub_register_map_control_tb.sv
// Self-checking bench of the hub register front end.
`timescale 1ns/10ps
module hub_register_map_control_tb;
  logic                       clk, rst_n, rom_done, cksum, lack, kack, ok, lr, fr, par;
  logic                       ce, rom_ld;
  logic [6:0]                 strap, tgt;
  logic [3:0]                 lock, map, en;
  logic [3:0][7:0]            evt;
  logic [7:0]                 lrd, krd, rd, v, a, pg;
  logic [4:0]                 c;
  hrmc_pkg::hrmc_req_t        lreq, kreq;
  hrmc_pkg::hrmc_tx_mode_t [1:0] txm;
  int                         bad_count = 0, compares = 0, lr_n = 0, fr_n = 0;
  hrmc_top u_dut (.i_clock(clk), .i_rst_n(rst_n), .i_clk_en(ce), .i_local_req(lreq),
    .o_local_ack(lack), .o_local_rdata(lrd), .i_link_req(kreq), .o_link_ack(kack),
    .o_link_rdata(krd), .i_strap_addr(strap), .i_rom_done(rom_done), .i_rom_cksum_ok(cksum),
    .i_rx_lock(lock), .i_rx_tx_map(map), .i_rx_event(evt), .o_target_addr(tgt),
    .o_rom_load(rom_ld), .o_full_reset(fr), .o_logic_reset(lr),
    .o_parity_check_en(par), .o_tx_mode(txm));
  hrmc_req_model u_loc (.i_clock(clk), .i_ack(lack), .i_rdata(lrd), .o_req(lreq));
  hrmc_req_model u_lnk (.i_clock(clk), .i_ack(kack), .i_rdata(krd), .o_req(kreq));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Pulses are counted so their number, not their cycle, is compared.
  always @(posedge clk) begin
    lr_n += lr;
    fr_n += fr;
  end
  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic check(input logic [7:0] s, e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  // Every access picks a channel at random so both paths carry reads and writes.
  task automatic acc(input logic lnk, w, input logic [7:0] ad, d);
    if (lnk) u_lnk.access(w, ad, d, $urandom % 3, rd, ok);
    else u_loc.access(w, ad, d, 0, rd, ok);
    if (!ok) begin
      bad_count++;
      complete_run();
    end
  endtask : acc
  task automatic rreg(input logic [7:0] ad);
    acc(1'($urandom), 1'b0, ad, 8'h00);
  endtask : rreg
  task automatic wreg(input logic [7:0] ad, d);
    acc(1'($urandom), 1'b1, ad, d);
  endtask : wreg
  function automatic hrmc_pkg::hrmc_tx_mode_t exp_mode(logic [4:0] g, logic [3:0] lk, mp,
                                                        logic t);
    logic any;
    any = |(lk & (t ? mp : ~mp));
    if (g[2] && !g[3]) return hrmc_pkg::HRMC_TX_HIZ;
    if (any) return hrmc_pkg::HRMC_TX_NORMAL;
    if (!g[4]) return hrmc_pkg::HRMC_TX_HIZ;
    return g[2] ? hrmc_pkg::HRMC_TX_LP11 : hrmc_pkg::HRMC_TX_HS0;
  endfunction : exp_mode
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(91));
    {rst_n, rom_done, lock, map, evt} = '0;
    ce = 1'b1;
    cksum = 1'($urandom);
    strap = 7'($urandom);
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    rreg(8'h04); check(rd & 8'h7F, 8'h02);
    check({7'h0, rom_ld}, 8'h01);
    rreg(8'h02); check(rd, 8'h1E);
    wreg(8'h90, 8'hA5); rreg(8'h90); check(rd, 8'h00);
    rom_done = 1'b1;
    rreg(8'h04); check(rd, {cksum, 7'h42});
    rreg(8'h00); check(rd, {strap, 1'b0});
    v = 8'($urandom);
    wreg(8'h00, {v[6:0], 1'b1}); rreg(8'h00); check(rd, {v[6:0], 1'b1});
    check({1'b0, tgt}, {1'b0, v[6:0]});
    wreg(8'h00, 8'hFE); rreg(8'h00); check(rd, {strap, 1'b0});
    $display("identifier test done");
    for (int k = 0; k < 12; k++) begin
      pg = k[0] ? 8'h4C : 8'h32;
      v = 8'($urandom);
      a = 8'(!k[0] ? 8'h33 + $urandom % 8 : k[1] ? 8'hD0 + $urandom % 16 : 8'h4E + $urandom % 50);
      // The first byte of the transmit and receive blocks is hit on purpose, with all ports enabled first.
      if (k < 2) a = k[0] ? 8'h4E : 8'h33;
      en = 4'($urandom % (k[0] ? 16 : 4));
      wreg(pg, k[0] ? 8'h0F : 8'h03); wreg(a, ~v); wreg(pg, {4'h0, en}); wreg(a, v);
      for (int p = 0; p < (k[0] ? 4 : 2); p++) begin
        wreg(pg, 8'(p << 4)); rreg(a); check(rd, en[p] ? v : ~v);
      end
    end
    $display("paging test done");
    wreg(8'h4C, 8'h20);
    v = 8'($urandom) | 8'h01;
    @(posedge clk);
    #1 evt[2] = v;
    @(posedge clk);
    #1 evt = '0;
    rreg(8'h4D); check(rd, v);
    rreg(8'h4D); check(rd, 8'h00);
    $display("event test done");
    for (int k = 0; k < 16; k++) begin
      c = 5'($urandom);
      lock = k < 6 ? 4'h0 : 4'($urandom);
      map = 4'($urandom);
      wreg(8'h02, {3'h7, c});
      repeat (2) @(posedge clk);
      #1;
      check({7'h0, par}, {7'h0, c[1]});
      for (int t = 0; t < 2; t++)
        check({6'h0, txm[t]}, {6'h0, exp_mode(c, lock, map, t[0])});
      rreg(8'h02); check(rd, {3'h0, c});
    end
    $display("output config test done");
    // While the enable is low the transmit state must not follow the new lock.
    ce = 1'b0;
    lock = ~lock;
    repeat (3) @(posedge clk);
    #1 check({6'h0, txm[0]}, {6'h0, exp_mode(c, ~lock, map, 1'b0)});
    ce = 1'b1;
    repeat (2) @(posedge clk);
    #1 check({6'h0, txm[0]}, {6'h0, exp_mode(c, lock, map, 1'b0)});
    $display("clock enable test done");
    wreg(8'h01, 8'hF8); rreg(8'h01); check(rd, 8'h20);
    wreg(8'h01, 8'h01); rreg(8'h01); check(rd, 8'h00);
    rreg(8'h02); check(rd, {3'h0, c});
    check(8'(lr_n), 8'h01);
    rom_done = 1'b0;
    wreg(8'h01, 8'h04); rreg(8'h04); check(rd & 8'h40, 8'h00);
    check({7'h0, rom_ld}, 8'h01);
    rom_done = 1'b1;
    rreg(8'h04); check(rd & 8'h40, 8'h40);
    check({7'h0, rom_ld}, 8'h00);
    rreg(8'h01); check(rd, 8'h00);
    wreg(8'h01, 8'h02);
    @(posedge clk);
    #1 check(8'(fr_n), 8'h01);
    rreg(8'h02); check(rd, 8'h1E);
    $display("soft reset test done");
    complete_run();
  end
endmodule : hub_register_map_control_tb
